//--- verilog/acl_pkg.sv
`default_nettype none
package acl_pkg;
	localparam int NSLOT  = 4;
	localparam int SLOT_W = 2;
	localparam int NWORD  = 22;
	localparam int V4_W   = 32;
	localparam int REL_W  = 3;

	// staging word indices; each word sits at byte address four times its index
	localparam int W_SRC_PAT = 0;
	localparam int W_SRC_DC  = 4;
	localparam int W_DST_PAT = 8;
	localparam int W_DST_DC  = 12;
	localparam int W_KEY     = 16;
	localparam int W_FLAGS   = 17;
	localparam int W_PROTO   = 18;
	localparam int W_PORT    = 19;
	localparam int W_SRANGE  = 20;
	localparam int W_DRANGE  = 21;

	localparam logic [7:0] A_COMMIT = 8'h58;
	localparam logic [7:0] A_STATUS = 8'h5C;

	// presence and option bits of the flags word
	localparam int F_CMT     = 0;
	localparam int F_VERD    = 1;
	localparam int F_SRC     = 2;
	localparam int F_DST     = 3;
	localparam int F_PROTO   = 4;
	localparam int F_ICMPT   = 5;
	localparam int F_ICMPC   = 6;
	localparam int F_IGMP    = 7;
	localparam int F_SPV     = 8;
	localparam int F_SPL     = 9;
	localparam int F_SPH     = 10;
	localparam int F_DPV     = 11;
	localparam int F_DPL     = 12;
	localparam int F_DPH     = 13;
	localparam int B_FRAG    = 16;
	localparam int B_PERMIT  = 17;
	localparam int B_SV6     = 18;
	localparam int B_DV6     = 19;
	localparam int REL_S_LSB = 20;
	localparam int REL_D_LSB = 24;

	localparam int C_CLR     = 8;
	localparam int S_ACC     = 0;
	localparam int S_REJ     = 1;
	localparam int S_VLD_LSB = 8;

	localparam logic [2:0] REL_LT = 3'h2;
	localparam logic [2:0] REL_GT = 3'h3;
	localparam logic [2:0] REL_EQ = 3'h4;
	localparam logic [2:0] REL_NE = 3'h5;

	localparam logic [7:0] PROTO_ICMP = 8'h01;
	localparam logic [7:0] PROTO_IGMP = 8'h02;

	typedef logic [NWORD-1:0][31:0] acl_words_t;

	typedef struct packed {
		logic [127:0] src;
		logic [127:0] dst;
		logic         v6;
		logic         first_frag;
		logic [7:0]   proto;
		logic [7:0]   icmp_type;
		logic [7:0]   icmp_code;
		logic [7:0]   igmp_type;
		logic [15:0]  sport;
		logic [15:0]  dport;
	} acl_pkt_t;

	typedef struct packed {
		logic              hit;
		logic              permit;
		logic [SLOT_W-1:0] slot;
	} acl_verdict_t;
endpackage
`default_nettype wire

//--- verilog/acl_matcher.sv
`timescale 1ns/1ps
`default_nettype none
module acl_matcher (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic                       wb_ack_o,
	output logic [31:0]                wb_dat_o,
	input  wire logic                  pkt_valid_i,
	input  wire acl_pkg::acl_pkt_t     pkt_i,
	output logic                       pkt_ready_o,
	output logic                       verdict_valid_o,
	output var acl_pkg::acl_verdict_t  verdict_o
);

	typedef struct packed {
		acl_pkg::acl_words_t                     stg;
		acl_pkg::acl_words_t [acl_pkg::NSLOT-1:0] tbl;
		logic [acl_pkg::NSLOT-1:0]               vld;
		logic                                    acc;
		logic                                    rej;
		logic                                    ack;
		logic [31:0]                             rdat;
		logic                                    vvld;
		acl_pkg::acl_verdict_t                   vout;
	} acl_state_t;

	acl_state_t                q;
	acl_state_t                d;
	logic [acl_pkg::NSLOT-1:0] hitv;
	logic                      hit_any;
	logic [acl_pkg::SLOT_W-1:0] hit_slot;
	logic                      lower_hit;
	logic                      req;
	logic                      wr_now;

	////////////////////////////////////////////////////////////////////////////
	// helper functions

	function automatic logic [127:0] addr_of(input acl_pkg::acl_words_t w, input int base);
		addr_of = {w[base+3], w[base+2], w[base+1], w[base]};
	endfunction

	function automatic logic [15:0] key_of(input acl_pkg::acl_words_t w);
		key_of = w[acl_pkg::W_KEY][15:0];
	endfunction

	function automatic logic addr_ok(
		input logic [127:0] pat,
		input logic [127:0] dc,
		input logic [127:0] a,
		input logic         rv6,
		input logic         pv6
	);
		logic [127:0] care;
		care = ~dc;
		// a v4 pattern lives in the low word; upper bits never take part
		if (!rv6) begin
			care[127:acl_pkg::V4_W] = '0;
		end
		addr_ok = (rv6 == pv6) && (((a ^ pat) & care) == '0);
	endfunction

	function automatic logic port_ok(
		input logic [15:0] p,
		input logic [15:0] v,
		input logic [2:0]  rel
	);
		case (rel)
			acl_pkg::REL_LT: port_ok = (p < v);
			acl_pkg::REL_GT: port_ok = (p > v);
			acl_pkg::REL_EQ: port_ok = (p == v);
			acl_pkg::REL_NE: port_ok = (p != v);
			// an undefined relation never matches rather than guessing
			default:         port_ok = 1'b0;
		endcase
	endfunction

	function automatic logic in_range(
		input logic [15:0] p,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		in_range = (p >= lo) && (p <= hi);
	endfunction

	function automatic logic rule_bad(input acl_pkg::acl_words_t w);
		logic [31:0] f;
		f = w[acl_pkg::W_FLAGS];
		rule_bad =
			(f[acl_pkg::F_CMT] && (|f[acl_pkg::F_DPH:acl_pkg::F_VERD])) ||
			(f[acl_pkg::F_VERD] && !f[acl_pkg::F_SRC] && !f[acl_pkg::F_DST]) ||
			(f[acl_pkg::F_SRC] && f[acl_pkg::F_DST] &&
			 (f[acl_pkg::B_SV6] != f[acl_pkg::B_DV6])) ||
			(f[acl_pkg::F_PROTO] && (f[acl_pkg::F_ICMPT] || f[acl_pkg::F_IGMP])) ||
			(f[acl_pkg::F_ICMPT] && f[acl_pkg::F_IGMP]) ||
			(f[acl_pkg::F_ICMPC] && !f[acl_pkg::F_ICMPT]) ||
			(f[acl_pkg::F_SPV] && f[acl_pkg::F_SPL]) ||
			(f[acl_pkg::F_DPV] && f[acl_pkg::F_DPL]) ||
			(f[acl_pkg::F_SPL] != f[acl_pkg::F_SPH]) ||
			(f[acl_pkg::F_DPL] != f[acl_pkg::F_DPH]);
	endfunction

	function automatic logic rule_hit(input acl_pkg::acl_words_t w, input acl_pkg::acl_pkt_t p);
		logic [31:0] f;
		logic [31:0] pr;
		logic        h;
		f = w[acl_pkg::W_FLAGS];
		pr = w[acl_pkg::W_PROTO];
		// comment entries and entries without a verdict never match
		h = f[acl_pkg::F_VERD] && !f[acl_pkg::F_CMT];
		// each check except the fragment one only runs when its field is present, else anything passes
		if (!f[acl_pkg::B_FRAG] && !p.first_frag) begin
			h = 1'b0;
		end
		// the dontcare words travel with their pattern flag
		if (f[acl_pkg::F_SRC] && !addr_ok(addr_of(w, acl_pkg::W_SRC_PAT),
			addr_of(w, acl_pkg::W_SRC_DC), p.src, f[acl_pkg::B_SV6], p.v6)) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_DST] && !addr_ok(addr_of(w, acl_pkg::W_DST_PAT),
			addr_of(w, acl_pkg::W_DST_DC), p.dst, f[acl_pkg::B_DV6], p.v6)) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_PROTO] && (p.proto != pr[7:0])) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_ICMPT] &&
			((p.proto != acl_pkg::PROTO_ICMP) || (p.icmp_type != pr[15:8]))) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_ICMPC] && (p.icmp_code != pr[23:16])) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_IGMP] &&
			((p.proto != acl_pkg::PROTO_IGMP) || (p.igmp_type != pr[31:24]))) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_SPL] && f[acl_pkg::F_SPH]) begin
			if (!in_range(p.sport, w[acl_pkg::W_SRANGE][15:0],
				w[acl_pkg::W_SRANGE][31:16])) begin
				h = 1'b0;
			end
		end else if (f[acl_pkg::F_SPV] && !port_ok(p.sport, w[acl_pkg::W_PORT][15:0],
			f[acl_pkg::REL_S_LSB +: acl_pkg::REL_W])) begin
			h = 1'b0;
		end
		if (f[acl_pkg::F_DPL] && f[acl_pkg::F_DPH]) begin
			if (!in_range(p.dport, w[acl_pkg::W_DRANGE][15:0],
				w[acl_pkg::W_DRANGE][31:16])) begin
				h = 1'b0;
			end
		end else if (f[acl_pkg::F_DPV] && !port_ok(p.dport, w[acl_pkg::W_PORT][31:16],
			f[acl_pkg::REL_D_LSB +: acl_pkg::REL_W])) begin
			h = 1'b0;
		end
		rule_hit = h;
	endfunction

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  sel
	);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// rule evaluation: all slots in parallel, lowest order key wins

	always_comb begin
		for (int i = 0; i < acl_pkg::NSLOT; i++) begin
			hitv[i] = q.vld[i] && rule_hit(q.tbl[i], pkt_i);
		end
	end

	always_comb begin
		hit_any = 1'b0;
		hit_slot = '0;
		lower_hit = 1'b0;
		// ties on the key go to the lower slot number
		for (int i = 0; i < acl_pkg::NSLOT; i++) begin
			if (hitv[i] && (!hit_any || (key_of(q.tbl[i]) < key_of(q.tbl[hit_slot])))) begin
				hit_any = 1'b1;
				hit_slot = acl_pkg::SLOT_W'(i);
			end
		end
		// checking aid only: any hit that outranks the chosen one
		for (int j = 0; j < acl_pkg::NSLOT; j++) begin
			if (hitv[j] && (key_of(q.tbl[j]) < key_of(q.tbl[hit_slot]))) begin
				lower_hit = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus slave and state update

	assign req = wb_cyc_i && wb_stb_i;
	assign wr_now = req && q.ack && wb_we_i;

	always_comb begin
		d = q;
		d.ack = req && !q.ack;
		d.vvld = pkt_valid_i;
		if (pkt_valid_i) begin
			d.vout.hit = hit_any;
			d.vout.permit = hit_any && q.tbl[hit_slot][acl_pkg::W_FLAGS][acl_pkg::B_PERMIT];
			d.vout.slot = hit_slot;
		end
		if (req && !q.ack) begin
			d.rdat = '0;
			if (wb_adr_i[7:2] < 6'(acl_pkg::NWORD)) begin
				d.rdat = q.stg[wb_adr_i[7:2]];
			end else if (wb_adr_i == acl_pkg::A_STATUS) begin
				d.rdat[acl_pkg::S_ACC] = q.acc;
				d.rdat[acl_pkg::S_REJ] = q.rej;
				d.rdat[acl_pkg::S_VLD_LSB +: acl_pkg::NSLOT] = q.vld;
			end
		end
		if (wr_now) begin
			if (wb_adr_i[7:2] < 6'(acl_pkg::NWORD)) begin
				d.stg[wb_adr_i[7:2]] = merge(q.stg[wb_adr_i[7:2]], wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == acl_pkg::A_STATUS) begin
				// write one to clear via byte lane 0; a commit is a separate write and sets again in a later cycle
				if (wb_sel_i[0] && wb_dat_i[acl_pkg::S_ACC]) begin
					d.acc = 1'b0;
				end
				if (wb_sel_i[0] && wb_dat_i[acl_pkg::S_REJ]) begin
					d.rej = 1'b0;
				end
			end else if (wb_adr_i == acl_pkg::A_COMMIT) begin
				if (wb_dat_i[acl_pkg::C_CLR]) begin
					d.vld[wb_dat_i[acl_pkg::SLOT_W-1:0]] = 1'b0;
				end else if (rule_bad(q.stg)) begin
					// a refused entry leaves the slot exactly as it was
					d.rej = 1'b1;
				end else begin
					d.tbl[wb_dat_i[acl_pkg::SLOT_W-1:0]] = q.stg;
					d.vld[wb_dat_i[acl_pkg::SLOT_W-1:0]] = 1'b1;
					d.acc = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	// one verdict per cycle, so the forwarding path is never held off
	assign pkt_ready_o = 1'b1;
	assign verdict_valid_o = q.vvld;
	assign verdict_o = q.vout;

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [31:0]  f0;
	logic [31:0]  fs;
	logic [127:0] src0;
	assign f0 = q.tbl[0][acl_pkg::W_FLAGS];
	assign fs = q.stg[acl_pkg::W_FLAGS];
	assign src0 = addr_of(q.tbl[0], acl_pkg::W_SRC_PAT);

	sequence s_commit;
		wr_now && (wb_adr_i == acl_pkg::A_COMMIT) && !wb_dat_i[acl_pkg::C_CLR];
	endsequence

	sequence s_refused;
		q.rej && (q.vld == $past(q.vld));
	endsequence

	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		(req && !q.ack) |=> q.ack ##1 !q.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a single pulse");

	property p_order;
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && hit_any) |-> !lower_hit;
	endproperty
	a_order: assert property (p_order) else $error("a higher-key rule won");

	property p_first;
		@(posedge clk_i) disable iff (rst_i)
		(pkt_valid_i && hit_any) |=> verdict_valid_o && verdict_o.hit &&
			(verdict_o.permit == $past(q.tbl[hit_slot][acl_pkg::W_FLAGS][acl_pkg::B_PERMIT]));
	endproperty
	a_first: assert property (p_first) else $error("verdict not from winner");

	property p_host;
		@(posedge clk_i) disable iff (rst_i)
		(q.vld[0] && f0[acl_pkg::F_SRC] && f0[acl_pkg::B_SV6] &&
		 (addr_of(q.tbl[0], acl_pkg::W_SRC_DC) == '0) && (pkt_i.src != src0)) |-> !hitv[0];
	endproperty
	a_host: assert property (p_host) else $error("host entry hit other source");

	property p_frag;
		@(posedge clk_i) disable iff (rst_i)
		(!pkt_i.first_frag && !f0[acl_pkg::B_FRAG]) |-> !hitv[0];
	endproperty
	a_frag: assert property (p_frag) else $error("later fragment hit entry");

	property p_range;
		@(posedge clk_i) disable iff (rst_i)
		(f0[acl_pkg::F_SPL] && f0[acl_pkg::F_SPH] &&
		 !in_range(pkt_i.sport, q.tbl[0][acl_pkg::W_SRANGE][15:0],
			q.tbl[0][acl_pkg::W_SRANGE][31:16])) |-> !hitv[0];
	endproperty
	a_range: assert property (p_range) else $error("port outside range hit");

	property p_comment;
		@(posedge clk_i) disable iff (rst_i)
		(s_commit and (fs[acl_pkg::F_CMT] && fs[acl_pkg::F_VERD])) |=> s_refused;
	endproperty
	a_comment: assert property (p_comment) else $error("mixed comment taken");

	property p_noaddr;
		@(posedge clk_i) disable iff (rst_i)
		(s_commit and (fs[acl_pkg::F_VERD] && !fs[acl_pkg::F_SRC] && !fs[acl_pkg::F_DST]))
			|=> s_refused;
	endproperty
	a_noaddr: assert property (p_noaddr) else $error("addressless entry taken");

	property p_family;
		@(posedge clk_i) disable iff (rst_i)
		(s_commit and (fs[acl_pkg::F_SRC] && fs[acl_pkg::F_DST] &&
			(fs[acl_pkg::B_SV6] != fs[acl_pkg::B_DV6]))) |=> s_refused;
	endproperty
	a_family: assert property (p_family) else $error("mixed families taken");

	property p_mix;
		@(posedge clk_i) disable iff (rst_i)
		(s_commit and (fs[acl_pkg::F_ICMPT] && fs[acl_pkg::F_IGMP])) |=> s_refused;
	endproperty
	a_mix: assert property (p_mix) else $error("icmp with igmp taken");

	property p_half;
		@(posedge clk_i) disable iff (rst_i)
		(s_commit and (fs[acl_pkg::F_DPL] != fs[acl_pkg::F_DPH])) |=> s_refused;
	endproperty
	a_half: assert property (p_half) else $error("half range taken");

	property p_store;
		@(posedge clk_i) disable iff (rst_i)
		(s_commit and !rule_bad(q.stg)) |=> q.acc &&
			q.vld[$past(wb_dat_i[acl_pkg::SLOT_W-1:0])] &&
			(q.tbl[$past(wb_dat_i[acl_pkg::SLOT_W-1:0])] == $past(q.stg));
	endproperty
	a_store: assert property (p_store) else $error("good entry not stored");

endmodule
`default_nettype wire

//--- bench/acl_pkt_src.sv
`timescale 1ns/1ps
`default_nettype none
module acl_pkt_src (
	input  wire logic              clk_i,
	input  wire logic              go_i,
	input  wire acl_pkg::acl_pkt_t pkt_i,
	output logic                   pkt_valid_o,
	output var acl_pkg::acl_pkt_t  pkt_o
);
	acl_pkg::acl_pkt_t last_q = '0;

	always_ff @(posedge clk_i) begin
		if (go_i)
			last_q <= pkt_i;
	end

	// idle header lines carry the inverse of the last packet, so a stale sample never matches
	assign pkt_valid_o = go_i;
	assign pkt_o       = go_i ? pkt_i : ~last_q;
endmodule
`default_nettype wire

//--- bench/ip_acl_rule_matcher_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ip_acl_rule_matcher_tb_top;
	logic                  clk_i, rst_i, cyc, stb, wem, wb_ack_o, go, pkt_valid;
	logic                  pkt_ready_o, verdict_valid_o, h;
	logic [7:0]            adr;
	logic [3:0]            sel, vm;
	logic [31:0]           dat, wb_dat_o, rd, sp, flip;
	logic [31:0]           w[22];
	acl_pkg::acl_pkt_t     p, pin, pkt;
	acl_pkg::acl_verdict_t verdict_o;
	int                    n_mismatch, total_checks;
	logic [31:0] rj[11] = '{32'h7, 32'h2, 32'h36, 32'hA6, 32'h96, 32'h706, 32'h3806,
		32'h206, 32'h406, 32'h2006, 32'h4000E};
	logic [31:0] fk[3] = '{32'h10, 32'h60, 32'h80};
	logic [7:0]  pk[3] = '{8'h11, 8'h01, 8'h02};
	logic [15:0] sv[4] = '{16'h0063, 16'h0064, 16'h01F4, 16'h01F5};

	acl_matcher dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(wem), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .pkt_valid_i(pkt_valid), .pkt_i(pkt), .pkt_ready_o(pkt_ready_o),
		.verdict_valid_o(verdict_valid_o), .verdict_o(verdict_o));
	acl_pkt_src src (.clk_i(clk_i), .go_i(go), .pkt_i(pin), .pkt_valid_o(pkt_valid),
		.pkt_o(pkt));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// entered just after a rising edge; ack and read data are taken at the edge itself,
	// and only the watchdog ends a wait that never gets its ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		wem <= we;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic load(input logic [1:0] s, input logic rej);
		for (int i = 0; i < acl_pkg::NWORD; i++)
			wb(1'b1, 8'(i * 4), w[i]);
		wb(1'b1, acl_pkg::A_COMMIT, {30'h0, s});
		if (!rej)
			vm[s] = 1'b1;
		wb(1'b0, acl_pkg::A_STATUS, 32'h0);
		`CHK(rd, {20'h0, vm, 6'h0, rej, ~rej})
		wb(1'b1, acl_pkg::A_STATUS, 32'h3);
	endtask

	task automatic clr();
		w = '{default: 32'h0};
		w[4] = 32'hFFFFFFFF;
		w[16] = 32'h1;
	endtask

	task automatic rnd();
		p.src = {$urandom, $urandom, $urandom, $urandom};
		p.dst = {$urandom, $urandom, $urandom, $urandom};
		p.v6 = 1'b0;
		p.first_frag = 1'b1;
		{p.proto, p.icmp_type, p.icmp_code, p.igmp_type} = $urandom;
		{p.sport, p.dport} = $urandom;
	endtask

	// slot is left open on a miss, so it is compared only on a hit
	task automatic send(input acl_pkg::acl_verdict_t e);
		go <= 1'b1;
		pin <= p;
		@(posedge clk_i);
		go <= 1'b0;
		@(negedge clk_i);
		`CHK(verdict_valid_o, 1'b1)
		`CHK({verdict_o.hit, verdict_o.permit}, {e.hit, e.permit})
		if (e.hit)
			`CHK(verdict_o.slot, e.slot)
		@(posedge clk_i);
	endtask

	function automatic logic rel(input logic [15:0] a, input logic [15:0] v, input logic [2:0] r);
		case (r)
			acl_pkg::REL_LT: return a < v;
			acl_pkg::REL_GT: return a > v;
			acl_pkg::REL_EQ: return a == v;
			acl_pkg::REL_NE: return a != v;
			default:         return 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////
	initial begin
		{rst_i, cyc, stb, wem, adr, dat, go, vm} = {1'b1, 48'h0};
		sel = 4'hF;
		pin = '0;
		void'($urandom(40));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, 8'h80, 32'hFFFFFFFF);
		wb(1'b0, 8'h80, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b1, 8'h40, 32'hAAAAAAAA);
		sel <= 4'h5;
		wb(1'b1, 8'h40, 32'h55555555);
		sel <= 4'hF;
		wb(1'b0, 8'h40, 32'h0);
		`CHK(rd, 32'hAA55AA55)
		clr();
		w[17] = 32'h1;
		load(2'h3, 1'b0);
		foreach (rj[i]) begin
			clr();
			w[17] = rj[i];
			load(2'h2, 1'b1);
		end
		$display("reject table done");
		for (int k = 0; k < 2; k++) begin
			clr();
			w[0] = $urandom;
			w[4] = k ? 32'h0 : 32'h0000FF01;
			w[16] = 32'h10;
			w[17] = 32'h00020006;
			load(2'h0, 1'b0);
			wb(1'b0, 8'h40, 32'h0);
			`CHK(rd, 32'h10)
			for (int i = 0; i < 16; i++) begin
				rnd();
				flip = (i % 2) ? $urandom : (i % 4 ? 32'h100 : 32'h0);
				p.src[31:0] = w[0] ^ flip;
				h = ((flip & ~w[4]) == 32'h0);
				send({h, h, 2'h0});
			end
		end
		sp = w[0];
		$display("wildcard done");
		clr();
		w[4] = 32'h0;
		w[8] = $urandom;
		w[12] = 32'hFF00000F;
		w[16] = 32'h8;
		w[17] = 32'h0000000A;
		load(2'h1, 1'b0);
		rnd();
		p.src[31:0] = sp;
		p.dst[31:0] = w[8] ^ 32'h0A000005;
		send({1'b1, 1'b0, 2'h1});
		p.dst[31:0] = w[8] ^ 32'h00000010;
		send({1'b1, 1'b1, 2'h0});
		wb(1'b1, acl_pkg::A_COMMIT, 32'h101);
		vm[1] = 1'b0;
		wb(1'b0, acl_pkg::A_STATUS, 32'h0);
		`CHK(rd[11:8], vm)
		p.dst[31:0] = w[8];
		send({1'b1, 1'b1, 2'h0});
		$display("order done");
		// the last pass gives the source an undefined relation, which never matches
		for (int k = 0; k < 5; k++) begin
			clr();
			w[17] = 32'h00020906 | (32'(k + 2) << 20) | (32'((k + 1) % 4 + 2) << 24);
			w[19] = $urandom;
			load(2'h2, 1'b0);
			for (int i = 0; i < 6; i++) begin
				rnd();
				p.sport = w[19][15:0] + 16'(i % 3) - 16'h1;
				p.dport = w[19][31:16] + 16'(i / 2 % 3) - 16'h1;
				h = rel(p.sport, w[19][15:0], w[17][22:20]) && rel(p.dport, w[19][31:16],
					w[17][26:24]);
				send({h, h, 2'h2});
			end
		end
		clr();
		w[17] = 32'h00023606;
		w[20] = 32'h01F40064;
		w[21] = 32'h00500040;
		load(2'h0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			rnd();
			p.sport = (i == 4) ? 16'h0064 : sv[i % 4];
			p.dport = (i == 4) ? 16'h0051 : (i[0] ? 16'h0050 : 16'h0040);
			h = (i == 1 || i == 2);
			send({h, h, 2'h0});
		end
		// drop the range entry so random ports cannot hit it later
		wb(1'b1, acl_pkg::A_COMMIT, 32'h100);
		vm[0] = 1'b0;
		$display("ports done");
		for (int k = 0; k < 2; k++) begin
			clr();
			w[17] = 32'h00020006 | (32'(k) << 16);
			load(2'h2, 1'b0);
			rnd();
			p.first_frag = 1'b0;
			send({1'(k), 1'(k), 2'h2});
			p.first_frag = 1'b1;
			send({1'b1, 1'b1, 2'h2});
		end
		for (int k = 0; k < 3; k++) begin
			clr();
			w[17] = 32'h00020006 | fk[k];
			w[18] = 32'h03050711;
			load(2'h2, 1'b0);
			rnd();
			p.proto = pk[k];
			{p.igmp_type, p.icmp_code, p.icmp_type} = 24'h030507;
			send({1'b1, 1'b1, 2'h2});
			p.icmp_code ^= 8'h01;
			h = (k != 1);
			send({h, h, 2'h2});
			p.igmp_type ^= 8'h01;
			h = (k == 0);
			send({h, h, 2'h2});
		end
		$display("protocol done");
		clr();
		w[4] = 32'h0;
		for (int i = 0; i < 4; i++)
			w[i] = $urandom;
		w[17] = 32'h00060006;
		load(2'h0, 1'b0);
		rnd();
		p.v6 = 1'b1;
		p.src = {w[3], w[2], w[1], w[0]};
		send({1'b1, 1'b1, 2'h0});
		p.src[100] ^= 1'b1;
		send({1'b0, 1'b0, 2'h0});
		`CHK(pkt_ready_o, 1'b1)
		$display("family done");
		end_of_test();
	end

	// the whole sequence needs a few thousand cycles; this leaves ample margin
	initial begin
		#(25 * 20000);
		n_mismatch++;
		end_of_test();
	end
endmodule
`default_nettype wire
